// file: bench/pad_partner.sv
// Pads with the memory, CAN and serial parties outside
`timescale 1ns/100ps
`default_nettype none
module pad_partner (
	input wire logic       i_clk_sys,
	input wire logic [4:0] i_out, i_oe, i_pullup, i_ext_en, i_ext_val,
	output logic     [4:0] o_pad
);
	logic [4:0] last_q;
	// Released pads with no pull-up and no outside driver toggle so stale levels never pass
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			if (i_oe[i]) o_pad[i] = i_out[i];
			else if (i_ext_en[i]) o_pad[i] = i_ext_val[i];
			else if (i_pullup[i]) o_pad[i] = 1'b1;
			else o_pad[i] = ~last_q[i];
		end
	end
	always_ff @(posedge i_clk_sys) last_q <= o_pad;
endmodule // pad_partner
`default_nettype wire

// file: bench/pin_function_properties.sv
// Port properties of the pin function select
`timescale 1ns/100ps
`default_nettype none
module pin_function_properties (
	input wire logic        i_clk_sys, i_reset, i_bus_drive_control,
	input wire logic        i_bus_active, i_data_access_n, i_pin_d1,
	input wire logic        i_chip_select_two_n, i_chip_select_three_n,
	input wire logic        i_can_unit2_transmit, i_serial0_transmit,
	input wire logic        i_port_e_peripheral_disable,
	input wire logic [15:0] i_port_d_peripheral_enable,
	input wire logic [15:0] i_peripheral_select_register,
	input wire logic [4:0]  i_gpio_out, i_gpio_dir_out,
	input wire logic        o_pin_d9, o_pin_d9_oe, o_pin_d0, o_pin_d0_oe,
	input wire logic        o_pin_d1, o_pin_d1_oe, o_pin_e0, o_pin_e0_oe,
	input wire logic        o_can_unit2_receive
);
	wire logic d0_per = i_port_d_peripheral_enable[0];
	wire logic d1_per = i_port_d_peripheral_enable[1];
	wire logic sel4 = i_peripheral_select_register[4];
	wire logic sel5 = i_peripheral_select_register[5];
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	chk_dsel_low: assert property (
		i_bus_active && !i_data_access_n |=> !o_pin_d9 && o_pin_d9_oe)
		else $error("data select not low");
	chk_idle_drive: assert property (
		!i_reset && !i_bus_active
		|=> o_pin_d9_oe == $past(i_bus_drive_control))
		else $error("idle drive wrong");
	chk_d0_gpio: assert property (
		!i_reset && !d0_per |=> o_pin_d0 == $past(i_gpio_out[0])
		&& o_pin_d0_oe == $past(i_gpio_dir_out[0])) else $error("d0 gpio");
	chk_d0_can_tx: assert property (
		d0_per && sel4 |=> !o_pin_d0
		&& o_pin_d0_oe == !$past(i_can_unit2_transmit)) else $error("can tx");
	chk_d0_chip_two: assert property (
		d0_per && !sel4 |=> o_pin_d0 == $past(i_chip_select_two_n))
		else $error("chip two");
	chk_d1_chip_three: assert property (
		d1_per && !sel5 |=> o_pin_d1 == $past(i_chip_select_three_n))
		else $error("chip three");
	chk_can_rx_path: assert property (
		(d1_per && sel5 && !i_pin_d1)[*4] |=> !o_can_unit2_receive
		&& !o_pin_d1_oe) else $error("can rx");
	chk_serial_tx_pin: assert property (
		!i_reset && !i_port_e_peripheral_disable |=> o_pin_e0_oe
		&& o_pin_e0 == $past(i_serial0_transmit)) else $error("serial tx");
	cov_dsel: cover property (i_bus_active && !i_data_access_n);
	cov_can: cover property (d1_per && sel5 && d0_per && sel4);
	cov_chip: cover property (d0_per && !sel4 && i_bus_drive_control);
endmodule // pin_function_properties
bind port_d_e_pin_function_select pin_function_properties i_props (.*);
`default_nettype wire

// file: bench/testbench.sv
// Directed test of the pin function select
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic i_clk_sys = 1'b0, i_reset = 1'b1, i_bus_drive_control = 1'b0;
	logic i_port_e_peripheral_disable = 1'b0, i_bus_active = 1'b0;
	logic i_data_access_n = 1'b1, i_chip_select_two_n = 1'b1;
	logic i_chip_select_three_n = 1'b1, i_can_unit2_transmit = 1'b1;
	logic i_serial0_transmit = 1'b1;
	logic [15:0] i_port_d_peripheral_enable = 16'h0000;
	logic [15:0] i_peripheral_select_register = 16'h0000;
	logic [15:0] i_port_d_pullup_enable = 16'hFFFF;
	logic [15:0] i_port_e_pullup_enable = 16'hFFFF;
	logic [4:0] i_gpio_out = 5'h01, i_gpio_dir_out = 5'h01;
	logic [4:0] ext_en = 5'h00, ext_val = 5'h00, o_gpio_in, pad;
	logic o_can_unit2_receive, o_serial0_receive, o_pin_d9, o_pin_d9_oe;
	logic o_pin_d0, o_pin_d0_oe, o_pin_d1, o_pin_d1_oe, o_pin_e0, o_pin_e0_oe;
	logic o_pin_e1, o_pin_e1_oe, o_pin_d9_pullup, o_pin_d0_pullup;
	logic o_pin_d1_pullup, o_pin_e0_pullup, o_pin_e1_pullup;
	wire logic i_pin_d0, i_pin_d1, i_pin_d9, i_pin_e0, i_pin_e1;
	wire logic [4:0] oe = {o_pin_e1_oe, o_pin_e0_oe, o_pin_d9_oe,
		o_pin_d1_oe, o_pin_d0_oe};
	wire logic [4:0] po = {o_pin_e1, o_pin_e0, o_pin_d9, o_pin_d1, o_pin_d0};
	wire logic [4:0] pu = {o_pin_e1_pullup, o_pin_e0_pullup,
		o_pin_d9_pullup, o_pin_d1_pullup, o_pin_d0_pullup};
	int error_cnt = 0;
	int num_checks = 0;
	assign {i_pin_e1, i_pin_e0, i_pin_d9, i_pin_d1, i_pin_d0} = pad;
	port_d_e_pin_function_select i_port_d_e_pin_function_select (.*);
	pad_partner i_pad_partner (.i_clk_sys(i_clk_sys), .i_out(po), .i_oe(oe),
		.i_pullup(pu), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));
	initial forever #4 i_clk_sys = ~i_clk_sys;
	task automatic step(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (400) @(posedge i_clk_sys);
		error_cnt++;
		wrap_up();
	end
	initial begin
		step(4);
		chk({oe, pu}, 10'h01F);
		@(posedge i_clk_sys);
		i_reset <= 1'b0;
		step(2);
		chk({po[3], po[0], oe}, 7'h69);
		@(posedge i_clk_sys);
		i_serial0_transmit <= 1'b0;
		ext_en <= 5'h10;
		step(5);
		chk({o_pin_e0, o_serial0_receive}, 2'h0);
		@(posedge i_clk_sys);
		i_bus_active <= 1'b1;
		i_data_access_n <= 1'b0;
		step(1);
		chk({o_pin_d9, o_pin_d9_oe}, 2'h1);
		@(posedge i_clk_sys);
		i_bus_active <= 1'b0;
		i_data_access_n <= 1'b1;
		step(1);
		chk(o_pin_d9_oe, 1'b0);
		@(posedge i_clk_sys);
		i_bus_drive_control <= 1'b1;
		i_port_d_peripheral_enable <= 16'h0003;
		i_chip_select_two_n <= 1'b0;
		i_chip_select_three_n <= 1'b0;
		step(1);
		chk({o_pin_d9_oe, o_pin_d1, o_pin_d0, oe[1:0]}, 5'h13);
		@(posedge i_clk_sys);
		i_peripheral_select_register <= 16'h0030;
		i_can_unit2_transmit <= 1'b0;
		ext_en <= 5'h12;
		step(5);
		chk({o_pin_d0, o_pin_d0_oe, o_pin_d1_oe, o_can_unit2_receive}, 4'h4);
		@(posedge i_clk_sys);
		i_can_unit2_transmit <= 1'b1;
		ext_en <= 5'h10;
		step(5);
		chk({o_pin_d0_oe, o_can_unit2_receive}, 2'h1);
		@(posedge i_clk_sys);
		i_port_d_peripheral_enable <= 16'h0000;
		step(1);
		chk({o_pin_d0, o_pin_d0_oe, o_pin_d1_oe}, 3'h6);
		@(posedge i_clk_sys);
		i_port_d_pullup_enable <= 16'hFDFC;
		step(1);
		chk(pu, 5'h18);
		@(posedge i_clk_sys);
		i_port_e_pullup_enable <= 16'hFFFC;
		i_port_e_peripheral_disable <= 1'b1;
		i_gpio_out <= 5'h09;
		i_gpio_dir_out <= 5'h09;
		step(5);
		chk(pu, 5'h00);
		chk({po[3], oe[4:3], o_gpio_in[4], o_serial0_receive}, 5'h15);
		@(posedge i_clk_sys);
		i_reset <= 1'b1;
		step(1);
		chk({oe, pu}, 10'h01F);
		@(posedge i_clk_sys);
		i_reset <= 1'b0;
		step(2);
		chk(oe, 5'h0D);
		wrap_up();
	end
endmodule // testbench
`default_nettype wire

// file: verilog/pin_function_pkg.sv
// Types for the port D / port E pin function select
`default_nettype none
package pin_function_pkg;
	typedef enum logic [1:0] {
		PIN_GPIO  = 2'h0,
		PIN_CHIP  = 2'h1,
		PIN_CAN   = 2'h2,
		PIN_SER   = 2'h3
	} pin_role_t;
endpackage
`default_nettype wire

// file: verilog/pin_function_regs.svh
// Bit positions and reset values for the port D / port E pin function select
`ifndef PIN_FUNCTION_REGS_SVH
`define PIN_FUNCTION_REGS_SVH

// Port D peripheral-enable bits
`define PDPE_PIN0_BIT 0
`define PDPE_PIN1_BIT 1
`define PDPE_RESET 16'h0000
// Peripheral-select bits
`define PSEL_PIN0_BIT 4
`define PSEL_PIN1_BIT 5
`define PSEL_RESET 16'h0000
// Port D pull-up enable bits
`define PDPU_PIN0_BIT 0
`define PDPU_PIN1_BIT 1
`define PDPU_PIN9_BIT 9
`define PDPU_RESET 16'hFFFF
// Port E pull-up enable bits
`define PEPU_PIN0_BIT 0
`define PEPU_PIN1_BIT 1
`define PEPU_RESET 16'hFFFF
// Bus drive control reset value: selects float when idle
`define BUS_DRIVE_RESET 1'h0
// Per-pin register reset values, pin order D0, D1, D9, E0, E1
`define SYNC_RESET 1'h0
`define OUT_RESET 5'h1F
`define OE_RESET 5'h00
`define PULL_RESET 5'h1F
`define GPIO_IN_RESET 5'h00
// Level shown by an unused receive input
`define RX_IDLE 1'h1

`endif

// file: verilog/port_d_e_pin_function_select.sv
// Pin function multiplexing for port D pins 0, 1, 9 and port E pins 0, 1
//
// Behaviour
// - Data-memory select pin is driven low during every external data access.
// - Chip select one resets acting as the data-memory select.
// - Idle bus: selects two, three and data float or drive per drive bit.
// - Chip select two asserts for a programmable external memory region.
// - Chip select three asserts for a programmable external memory region.
// - Port D pin 0 resets as GPIO; enable bit 0 gives it away.
// - Select bit 4 picks chip select two or CAN transmit for pin 0.
// - Port D pin 1 resets as GPIO; enable bit 1 gives it away.
// - Select bit 5 picks chip select three or CAN receive for pin 1.
// - Clearing pull-up bits 9, 0, 1 disables port D pin pull-ups.
// - Clearing port E pull-up bits 0, 1 disables serial pin pull-ups.
// - Port E pins 0 and 1 reset to the serial function.
// - Serial mode: port E pin 0 carries serial 0 transmit.
// - Serial mode: port E pin 1 carries serial 0 receive.
// - Each pin's GPIO direction, except D9's, is set independently.
// - CAN receive pin has an internal pull-up.
`timescale 1ns/100ps
`default_nettype none
`include "pin_function_regs.svh"

module port_d_e_pin_function_select (
	// Clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset,
	// Configuration
	input  wire logic        i_bus_drive_control,
	input  wire logic [15:0] i_port_d_peripheral_enable,
	input  wire logic [15:0] i_peripheral_select_register,
	input  wire logic [15:0] i_port_d_pullup_enable,
	input  wire logic [15:0] i_port_e_pullup_enable,
	input  wire logic        i_port_e_peripheral_disable,
	// GPIO data and direction, index 0..4 = D0, D1, D9, E0, E1
	input  wire logic [4:0]  i_gpio_out,
	input  wire logic [4:0]  i_gpio_dir_out,
	output logic      [4:0]  o_gpio_in,
	// External memory interface strobes, active low except i_bus_active, which is active high
	input  wire logic        i_bus_active,
	input  wire logic        i_data_access_n,
	input  wire logic        i_chip_select_two_n,
	input  wire logic        i_chip_select_three_n,
	// CAN and serial peripheral signals
	input  wire logic        i_can_unit2_transmit,
	output logic             o_can_unit2_receive,
	input  wire logic        i_serial0_transmit,
	output logic             o_serial0_receive,
	// Data-memory select pin (port D pin 9)
	input  wire logic        i_pin_d9,
	output logic             o_pin_d9,
	output logic             o_pin_d9_oe,
	output logic             o_pin_d9_pullup,
	// Port D pin 0
	input  wire logic        i_pin_d0,
	output logic             o_pin_d0,
	output logic             o_pin_d0_oe,
	output logic             o_pin_d0_pullup,
	// Port D pin 1
	input  wire logic        i_pin_d1,
	output logic             o_pin_d1,
	output logic             o_pin_d1_oe,
	output logic             o_pin_d1_pullup,
	// Port E pin 0
	input  wire logic        i_pin_e0,
	output logic             o_pin_e0,
	output logic             o_pin_e0_oe,
	output logic             o_pin_e0_pullup,
	// Port E pin 1
	input  wire logic        i_pin_e1,
	output logic             o_pin_e1,
	output logic             o_pin_e1_oe,
	output logic             o_pin_e1_pullup
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Pads are asynchronous: two flops per pin before any logic reads them
	wire  [4:0] pin_raw = {i_pin_e1, i_pin_e0, i_pin_d9, i_pin_d1, i_pin_d0};
	wire  [4:0] pin_sync_q;

	for (genvar b = 0; b < 5; b++) begin : g_sync
		logic meta_q;
		logic sync_q;

		always_ff @(posedge i_clk_sys or posedge i_reset) begin
			if (i_reset) begin
				meta_q <= `SYNC_RESET;
				sync_q <= `SYNC_RESET;
			end else begin
				meta_q <= pin_raw[b];
				sync_q <= meta_q;
			end
		end

		// Only the second flop is read beyond this loop
		assign pin_sync_q[b] = sync_q;
	end

	// ------------------------------------------------------------
	// Pin role decode
	// ------------------------------------------------------------
	pin_function_pkg::pin_role_t role_d0;
	pin_function_pkg::pin_role_t role_d1;
	pin_function_pkg::pin_role_t role_e0;
	pin_function_pkg::pin_role_t role_e1;

	wire en_d0  = i_port_d_peripheral_enable[`PDPE_PIN0_BIT];
	wire en_d1  = i_port_d_peripheral_enable[`PDPE_PIN1_BIT];
	wire sel_d0 = i_peripheral_select_register[`PSEL_PIN0_BIT];
	wire sel_d1 = i_peripheral_select_register[`PSEL_PIN1_BIT];
	wire ser_e  = ~i_port_e_peripheral_disable;

	assign role_d0 = !en_d0 ? pin_function_pkg::PIN_GPIO :
		(sel_d0 ? pin_function_pkg::PIN_CAN : pin_function_pkg::PIN_CHIP);
	assign role_d1 = !en_d1 ? pin_function_pkg::PIN_GPIO :
		(sel_d1 ? pin_function_pkg::PIN_CAN : pin_function_pkg::PIN_CHIP);
	assign role_e0 = ser_e ? pin_function_pkg::PIN_SER :
		pin_function_pkg::PIN_GPIO;
	assign role_e1 = role_e0;

	// ------------------------------------------------------------
	// Output values and enables (next state)
	// ------------------------------------------------------------
	// Selects float when the bus is idle unless drive-control is set
	wire sel_drive = i_bus_active | i_bus_drive_control;

	logic [4:0] out_d;
	logic [4:0] oe_d;
	logic [4:0] out_q;
	logic [4:0] oe_q;

	always_comb begin
		out_d = i_gpio_out;
		oe_d  = i_gpio_dir_out;
		// Port D pin 9 is always the data-memory select (chip select one)
		out_d[2] = i_data_access_n;
		oe_d[2]  = sel_drive;
		unique case (role_d0)
			pin_function_pkg::PIN_CHIP: begin
				out_d[0] = i_chip_select_two_n;
				oe_d[0]  = sel_drive;
			end
			pin_function_pkg::PIN_CAN: begin
				// Open drain: drive only the dominant low level
				out_d[0] = 1'h0;
				oe_d[0]  = ~i_can_unit2_transmit;
			end
			default: begin
			end
		endcase
		unique case (role_d1)
			pin_function_pkg::PIN_CHIP: begin
				out_d[1] = i_chip_select_three_n;
				oe_d[1]  = sel_drive;
			end
			pin_function_pkg::PIN_CAN: begin
				out_d[1] = 1'h0;
				oe_d[1]  = 1'h0;
			end
			default: begin
			end
		endcase
		if (role_e0 == pin_function_pkg::PIN_SER) begin
			out_d[3] = i_serial0_transmit;
			oe_d[3]  = 1'h1;
		end
		if (role_e1 == pin_function_pkg::PIN_SER) begin
			out_d[4] = 1'h0;
			oe_d[4]  = 1'h0;
		end
	end

	// Outputs registered; enables off during reset
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			out_q <= `OUT_RESET;
			oe_q  <= `OE_RESET;
		end else begin
			out_q <= out_d;
			oe_q  <= oe_d;
		end
	end

	assign o_pin_d0    = out_q[0];
	assign o_pin_d1    = out_q[1];
	assign o_pin_d9    = out_q[2];
	assign o_pin_e0    = out_q[3];
	assign o_pin_e1    = out_q[4];
	assign o_pin_d0_oe = oe_q[0];
	assign o_pin_d1_oe = oe_q[1];
	assign o_pin_d9_oe = oe_q[2];
	assign o_pin_e0_oe = oe_q[3];
	assign o_pin_e1_oe = oe_q[4];

	// ------------------------------------------------------------
	// Pull-ups
	// ------------------------------------------------------------
	logic [4:0] pull_q;
	wire  [4:0] pull_d = {
		i_port_e_pullup_enable[`PEPU_PIN1_BIT],
		i_port_e_pullup_enable[`PEPU_PIN0_BIT],
		i_port_d_pullup_enable[`PDPU_PIN9_BIT],
		i_port_d_pullup_enable[`PDPU_PIN1_BIT],
		i_port_d_pullup_enable[`PDPU_PIN0_BIT]
	};

	// Pull-ups on during reset
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset)
			pull_q <= `PULL_RESET;
		else
			pull_q <= pull_d;
	end

	assign o_pin_d0_pullup = pull_q[0];
	assign o_pin_d1_pullup = pull_q[1];
	assign o_pin_d9_pullup = pull_q[2];
	assign o_pin_e0_pullup = pull_q[3];
	assign o_pin_e1_pullup = pull_q[4];

	// ------------------------------------------------------------
	// Input returns
	// ------------------------------------------------------------
	logic [4:0] gpio_in_q;
	logic       can_rx_q;
	logic       ser_rx_q;

	// Receive inputs idle high when the pin is not handed to them, so the
	// CAN unit sees recessive and the serial unit an idle line
	wire can_rx_sel = (role_d1 == pin_function_pkg::PIN_CAN);
	wire ser_rx_sel = (role_e1 == pin_function_pkg::PIN_SER);
	wire can_rx_d   = can_rx_sel ? pin_sync_q[1] : `RX_IDLE;
	wire ser_rx_d   = ser_rx_sel ? pin_sync_q[4] : `RX_IDLE;

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			gpio_in_q <= `GPIO_IN_RESET;
			can_rx_q  <= `RX_IDLE;
			ser_rx_q  <= `RX_IDLE;
		end else begin
			gpio_in_q <= pin_sync_q;
			can_rx_q  <= can_rx_d;
			ser_rx_q  <= ser_rx_d;
		end
	end

	assign o_gpio_in           = gpio_in_q;
	assign o_can_unit2_receive = can_rx_q;
	assign o_serial0_receive   = ser_rx_q;

endmodule // port_d_e_pin_function_select

`default_nettype wire
